// ### sil_pkg.sv
// Package with register map, field layout and carrier types for the sensor interrupt logic.
// Functional notes
// - The interrupt pin is driven only while the output enable bit, bit 0 of the interrupt configuration register, is one.
// - The device forms the bitwise AND of the interrupt enable register and the interrupt status register.
// - The interrupt pin is asserted whenever any bit of that masked result is one.
// - A one written to a status bit clears that bit, and a zero leaves it unchanged.
// - Status bits are set from sequencer events as steered by the enable register; the two mode registers are stored only.
// - Proximity one sits at status bit 2, proximity two at bit 3, proximity three at bit 4 and ambient light at bits 1:0.
// - Proximity one raises a status bit after every sample only while enable bit 2 is one.
// - Proximity two raises a status bit after every sample only while enable bit 3 is one.
// - Proximity three raises a status bit after every sample only while enable bit 4 is one.
// - Ambient light enable code 00 gives no interrupt and code 01 sets the light status after every visible or UV sample.
package sil_pkg;
  localparam logic [7:0] SIL_ADDR_INT_CFG = 8'h03;
  localparam logic [7:0] SIL_ADDR_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] SIL_ADDR_IRQ_MODE_FIRST = 8'h05;
  localparam logic [7:0] SIL_ADDR_IRQ_MODE_SECOND = 8'h06;
  localparam logic [7:0] SIL_ADDR_IRQ_STATUS = 8'h21;
  localparam logic [7:0] SIL_RST_INT_CFG = 8'h00;
  localparam logic [7:0] SIL_RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] SIL_RST_IRQ_MODE = 8'h00;
  localparam logic [7:0] SIL_RST_IRQ_STATUS = 8'h00;
  localparam int SIL_BIT_INT_OE = 0;
  localparam int SIL_BIT_PROX_ONE = 2;
  localparam int SIL_BIT_PROX_TWO = 3;
  localparam int SIL_BIT_PROX_THREE = 4;
  localparam int SIL_LIGHT_LSB = 0;
  localparam logic [7:0] SIL_STATUS_IMPL_MASK = 8'h1f;
  localparam logic [7:0] SIL_ENABLE_IMPL_MASK = 8'h1f;
  localparam logic [1:0] SIL_LIGHT_OFF = 2'h0;
  localparam logic [1:0] SIL_LIGHT_EVERY = 2'h1;
  localparam int SIL_NUM_SRC = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sil_reg_req_t;

  typedef struct packed {
    logic prox_one;
    logic prox_two;
    logic prox_three;
    logic light;
  } sil_sample_t;
endpackage

// ### sil_src_flag.sv
// One sticky status flag with event set and write-one clear.
`timescale 1ns/1ns
module sil_src_flag
  import sil_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic set_ev,
  input wire logic clr_ev,
  output logic flag_r
);
  logic flag_nxt;

  // The set wins over a clear in the same cycle so no sample is lost.
  assign flag_nxt = set_ev ? 1'b1 : (clr_ev ? 1'b0 : flag_r);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end
endmodule

// ### sil_irq_top.sv
// Interrupt configuration, enable, mode and status registers with the interrupt pin drive.
`timescale 1ns/1ns
module sil_irq_top
  import sil_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input sil_reg_req_t reg_req,
  input sil_sample_t sample_done,
  output logic [7:0] reg_rdata_r,
  output logic int_pin_o_r,
  output logic int_pin_oe_r
);
  logic [7:0] int_cfg_r;
  logic [7:0] irq_enable_r;
  logic [7:0] irq_mode_first_r;
  logic [7:0] irq_mode_second_r;
  logic [7:0] reg_rdata_nxt;
  logic [SIL_NUM_SRC-1:0] flag_r;
  logic [SIL_NUM_SRC-1:0] set_ev;
  logic [SIL_NUM_SRC-1:0] clr_ev;

  wire sel_cfg = reg_req.addr == SIL_ADDR_INT_CFG;
  wire sel_en = reg_req.addr == SIL_ADDR_IRQ_ENABLE;
  wire sel_m1 = reg_req.addr == SIL_ADDR_IRQ_MODE_FIRST;
  wire sel_m2 = reg_req.addr == SIL_ADDR_IRQ_MODE_SECOND;
  wire sel_st = reg_req.addr == SIL_ADDR_IRQ_STATUS;
  wire status_clr = reg_req.wr && sel_st;

  wire prox_one_irq_enable = irq_enable_r[SIL_BIT_PROX_ONE];
  wire prox_two_irq_enable = irq_enable_r[SIL_BIT_PROX_TWO];
  wire prox_three_irq_enable = irq_enable_r[SIL_BIT_PROX_THREE];
  wire [1:0] light_irq_enable = irq_enable_r[SIL_LIGHT_LSB+1:SIL_LIGHT_LSB];

  // Threshold modes are not modelled, so the mode registers are stored only and never widen the set terms.
  assign set_ev[0] = sample_done.prox_one && prox_one_irq_enable;
  assign set_ev[1] = sample_done.prox_two && prox_two_irq_enable;
  assign set_ev[2] = sample_done.prox_three && prox_three_irq_enable;
  assign set_ev[3] = sample_done.light && (light_irq_enable == SIL_LIGHT_EVERY);

  assign clr_ev[0] = status_clr && reg_req.wdata[SIL_BIT_PROX_ONE];
  assign clr_ev[1] = status_clr && reg_req.wdata[SIL_BIT_PROX_TWO];
  assign clr_ev[2] = status_clr && reg_req.wdata[SIL_BIT_PROX_THREE];
  assign clr_ev[3] = status_clr && reg_req.wdata[SIL_LIGHT_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < SIL_NUM_SRC; gi++)
    begin : g_flag
      sil_src_flag u_flag (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .set_ev(set_ev[gi]),
        .clr_ev(clr_ev[gi]),
        .flag_r(flag_r[gi])
      );
    end
  endgenerate

  wire prox_one_irq_flag = flag_r[0];
  wire prox_two_irq_flag = flag_r[1];
  wire prox_three_irq_flag = flag_r[2];
  // Light status is a two-bit field; only its low bit is ever set by per-sample events.
  wire [1:0] light_irq_flag = {1'b0, flag_r[3]};
  wire [7:0] irq_status = {3'h0, prox_three_irq_flag, prox_two_irq_flag, prox_one_irq_flag,
                           light_irq_flag};
  wire [7:0] masked = irq_status & irq_enable_r;
  wire int_active = |masked;
  wire int_oe_nxt = int_cfg_r[SIL_BIT_INT_OE];

  assign reg_rdata_nxt = sel_cfg ? int_cfg_r :
                         sel_en ? irq_enable_r :
                         sel_m1 ? irq_mode_first_r :
                         sel_m2 ? irq_mode_second_r :
                         sel_st ? irq_status : 8'h00;

  // Each register has its own short process, so a write to one address can never disturb another.
  wire cfg_we = reg_req.wr && sel_cfg;
  wire en_we = reg_req.wr && sel_en;
  wire m1_we = reg_req.wr && sel_m1;
  wire m2_we = reg_req.wr && sel_m2;
  wire [7:0] int_cfg_nxt = cfg_we ? (reg_req.wdata & 8'h01) : int_cfg_r;
  wire [7:0] irq_enable_nxt = en_we ? (reg_req.wdata & SIL_ENABLE_IMPL_MASK) : irq_enable_r;
  wire [7:0] irq_mode_first_nxt = m1_we ? reg_req.wdata : irq_mode_first_r;
  wire [7:0] irq_mode_second_nxt = m2_we ? reg_req.wdata : irq_mode_second_r;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      int_cfg_r <= SIL_RST_INT_CFG;
    else
      int_cfg_r <= int_cfg_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irq_enable_r <= SIL_RST_IRQ_ENABLE;
    else
      irq_enable_r <= irq_enable_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irq_mode_first_r <= SIL_RST_IRQ_MODE;
    else
      irq_mode_first_r <= irq_mode_first_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irq_mode_second_r <= SIL_RST_IRQ_MODE;
    else
      irq_mode_second_r <= irq_mode_second_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata_r <= 8'h00;
    else if (reg_req.rd)
      reg_rdata_r <= reg_rdata_nxt;
  end

  // The pin is active low and open drain style: it pulls low only when enabled and pending.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      int_pin_o_r <= 1'b1;
      int_pin_oe_r <= 1'b0;
    end
    else
    begin
      int_pin_o_r <= ~int_active;
      int_pin_oe_r <= int_oe_nxt && int_active;
    end
  end

  pin_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    int_pin_oe_r |-> $past(int_cfg_r[SIL_BIT_INT_OE]))
    else $error("pin driven while output disabled");

  cfg_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !int_cfg_r[SIL_BIT_INT_OE] |=> !int_pin_oe_r)
    else $error("pin driven after output disable");

  pin_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 (int_pin_o_r == ~$past(|(irq_status & irq_enable_r))))
    else $error("pin level not masked status");

  pin_assert_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (int_cfg_r[SIL_BIT_INT_OE] && int_active) |=> int_pin_oe_r)
    else $error("pending interrupt not driven");

  pin_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !int_active |=> !int_pin_oe_r)
    else $error("pin driven with nothing pending");

  status_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flag_r[0] && !clr_ev[0]) |=> flag_r[0])
    else $error("flag dropped without host clear");

  set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (set_ev[0] && clr_ev[0]) |=> flag_r[0])
    else $error("clear beat a same cycle set");

  status_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clr_ev[1] && !set_ev[1]) |=> !flag_r[1])
    else $error("write one did not clear");

  light_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clr_ev[3] && !set_ev[3]) |=> !flag_r[3])
    else $error("write one did not clear light");

  zero_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (status_clr && !reg_req.wdata[SIL_BIT_PROX_TWO] && flag_r[1]) |=> flag_r[1])
    else $error("zero write cleared a flag");

  status_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_req.rd && sel_st) |=> (reg_rdata_r[SIL_BIT_PROX_THREE] == $past(flag_r[2]) && !reg_rdata_r[SIL_LIGHT_LSB+1]))
    else $error("status bits read from wrong place");

  prox_one_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sample_done.prox_one && prox_one_irq_enable) |=> irq_status[SIL_BIT_PROX_ONE])
    else $error("prox one not set");

  prox_one_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!flag_r[0] && !prox_one_irq_enable) |=> !flag_r[0])
    else $error("prox one set while disabled");

  prox_two_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sample_done.prox_two && prox_two_irq_enable) |=> irq_status[SIL_BIT_PROX_TWO])
    else $error("prox two not set");

  prox_two_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!flag_r[1] && !prox_two_irq_enable) |=> !flag_r[1])
    else $error("prox two set while disabled");

  prox_three_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sample_done.prox_three && prox_three_irq_enable) |=> irq_status[SIL_BIT_PROX_THREE])
    else $error("prox three not set");

  prox_three_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!flag_r[2] && !prox_three_irq_enable) |=> !flag_r[2])
    else $error("prox three set while disabled");

  light_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sample_done.light && light_irq_enable == SIL_LIGHT_EVERY) |=> irq_status[SIL_LIGHT_LSB])
    else $error("light not set");

  light_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!flag_r[3] && light_irq_enable == SIL_LIGHT_OFF) |=> !flag_r[3])
    else $error("light set while disabled");

  light_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!flag_r[3] && light_irq_enable != SIL_LIGHT_EVERY) |=> !flag_r[3])
    else $error("light set for off code");

  pin_fire_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(int_pin_oe_r));
  ack_c: cover property (@(posedge core_clk) disable iff (!rst_n) int_pin_oe_r ##1 status_clr ##2 !int_pin_oe_r);
  set_clear_c: cover property (@(posedge core_clk) disable iff (!rst_n) set_ev[0] && clr_ev[0]);
  light_code_c: cover property (@(posedge core_clk) disable iff (!rst_n) sample_done.light && light_irq_enable[1]);
  mode_write_c: cover property (@(posedge core_clk) disable iff (!rst_n) m1_we ##[1:4] m2_we);
endmodule

// ### sil_host_model.sv
// Host model that reaches the interrupt registers through the byte register port.
`timescale 1ns/1ns
module sil_host_model
  import sil_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] rdata,
  output sil_reg_req_t req = '0
);
  // A released bus shows inverted address and data, so stale values never pass for a new request.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk) req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk) req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(negedge core_clk) q = w ? d : rdata;
  endtask
  task automatic ack(output logic [7:0] seen);
    acc(1'b0, SIL_ADDR_IRQ_STATUS, 8'h00, seen);
    acc(1'b1, SIL_ADDR_IRQ_STATUS, seen, seen);
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the sensor interrupt logic, driven through the host model.
`timescale 1ns/1ns
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin \
  $display("Error %s expected %h seen %h", nm, e, s); n_fail++; end end
module tb_top;
  import sil_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0;
  sil_reg_req_t reg_req;
  sil_sample_t sample_done = '0;
  logic [7:0] reg_rdata_r, rv;
  logic int_pin_o_r, int_pin_oe_r;
  int n_fail = 0, tests_run = 0, cycles = 0;
  always #4 core_clk = ~core_clk;
  sil_irq_top sil_irq_top_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .sample_done(sample_done),
    .reg_rdata_r(reg_rdata_r), .int_pin_o_r(int_pin_o_r), .int_pin_oe_r(int_pin_oe_r));
  sil_host_model sil_host_model_inst (.core_clk(core_clk), .rdata(reg_rdata_r), .req(reg_req));
  task automatic test_done(input int hang);
    n_fail += hang;
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk)
    if (cycles++ == 3000)
      test_done(1);
  task automatic io(input bit wr, input logic [7:0] a, input logic [7:0] d);
    sil_host_model_inst.acc(wr, a, d, rv);
    if (!wr) `CHK("register", d, rv)
  endtask
  task automatic pulse(input logic [3:0] ev);
    @(posedge core_clk) sample_done <= ev;
    @(posedge core_clk) sample_done <= '0;
  endtask
  task automatic pin(input logic on);
    repeat (3) @(negedge core_clk);
    `CHK("pin_level", 8'(!on), 8'(int_pin_oe_r ? int_pin_o_r : 1'b1))
  endtask
  task automatic t_chan();
    logic [7:0] sb [4] = '{8'h04, 8'h08, 8'h10, 8'h01};
    io(0, 8'h40, 8'h00);
    io(1, SIL_ADDR_INT_CFG, 8'h01);
    io(1, SIL_ADDR_IRQ_ENABLE, 8'hfd);
    io(0, SIL_ADDR_IRQ_ENABLE, 8'h1d);
    for (int i = 0; i < 4; i++)
    begin
      pulse(4'h8 >> i);
      pin(1'b1);
      sil_host_model_inst.ack(rv);
      `CHK("status", sb[i], rv)
      pin(1'b0);
    end
  endtask
  task automatic t_mask();
    io(1, SIL_ADDR_IRQ_ENABLE, 8'h02);
    pulse(4'hf);
    io(1, SIL_ADDR_IRQ_ENABLE, 8'h03);
    pulse(4'hf);
    io(1, SIL_ADDR_IRQ_ENABLE, 8'h00);
    pulse(4'hf);
    io(0, SIL_ADDR_IRQ_STATUS, 8'h00);
    io(1, SIL_ADDR_IRQ_ENABLE, 8'h1d);
    pulse(4'hf);
    io(1, SIL_ADDR_IRQ_STATUS, 8'h00);
    io(0, SIL_ADDR_IRQ_STATUS, 8'h1d);
    io(1, SIL_ADDR_INT_CFG, 8'h00);
    pin(1'b0);
    io(1, SIL_ADDR_INT_CFG, 8'h01);
    io(1, SIL_ADDR_IRQ_ENABLE, 8'h00);
    pin(1'b0);
    io(1, SIL_ADDR_IRQ_STATUS, 8'h14);
    io(1, SIL_ADDR_IRQ_ENABLE, 8'h08);
    pin(1'b1);
    io(0, SIL_ADDR_IRQ_STATUS, 8'h09);
  endtask
  task automatic t_regs();
    io(1, SIL_ADDR_IRQ_MODE_FIRST, 8'ha5);
    io(1, SIL_ADDR_IRQ_MODE_SECOND, 8'h5a);
    io(0, SIL_ADDR_IRQ_MODE_FIRST, 8'ha5);
    io(0, SIL_ADDR_IRQ_MODE_SECOND, 8'h5a);
    io(1, SIL_ADDR_INT_CFG, 8'hff);
    io(0, SIL_ADDR_INT_CFG, 8'h01);
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    io(0, SIL_ADDR_INT_CFG, SIL_RST_INT_CFG);
    io(0, SIL_ADDR_IRQ_ENABLE, SIL_RST_IRQ_ENABLE);
    io(0, SIL_ADDR_IRQ_MODE_FIRST, SIL_RST_IRQ_MODE);
    io(0, SIL_ADDR_IRQ_MODE_SECOND, SIL_RST_IRQ_MODE);
    io(0, SIL_ADDR_IRQ_STATUS, SIL_RST_IRQ_STATUS);
    pin(1'b0);
  endtask
  task automatic t_race();
    io(1, SIL_ADDR_IRQ_ENABLE, 8'h04);
    fork
      pulse(4'h8);
      io(1, SIL_ADDR_IRQ_STATUS, 8'h04);
    join
    io(0, SIL_ADDR_IRQ_STATUS, 8'h04);
    io(1, SIL_ADDR_IRQ_STATUS, 8'h04);
    io(0, SIL_ADDR_IRQ_STATUS, 8'h00);
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_chan();
    t_mask();
    t_regs();
    t_race();
    test_done(0);
  end
endmodule
